//--- logic/pia_map.svh
// Purpose: register offsets, field masks and frame constants
// Assumes: 16-bit management registers, 5-bit register addresses
// Notes: definitions only
`ifndef PIA_MAP_SVH
`define PIA_MAP_SVH
`define PIA_REG_ID_LOW 5'h03
`define PIA_REG_ADV 5'h04
`define PIA_REG_LP 5'h05
`define PIA_ADV_RST 16'h01e1
`define PIA_ADV_WR_MASK 16'hadff
`define PIA_LP_MASK 16'hefff
`define PIA_ADV_NP 15
`define PIA_ADV_RF 13
`define PIA_ADV_ASYM 11
`define PIA_ADV_PAUSE 10
`define PIA_ADV_T4 9
`define PIA_ADV_TECH_MSB 8
`define PIA_ADV_TECH_LSB 5
`define PIA_ADV_UPPER_LSB 6
`define PIA_SEL_8023 5'h01
`define PIA_PRE_LAST 6'h1f
`define PIA_ADDR_LAST 6'h09
`define PIA_DATA_LAST 6'h0f
`define PIA_OP_WR 2'h1
`define PIA_OP_RD 2'h2
`define PIA_GAP_NS 500
`define PIA_CLK_NS 10
`define PIA_GAP_CYC ((`PIA_GAP_NS + `PIA_CLK_NS - 1) / `PIA_CLK_NS)
`endif

//--- logic/pia_pkg.sv
// Purpose: shared types of the identifier and advertisement bank
// Assumes: nothing
// Notes: constants live in pia_map.svh
`default_nettype none
package pia_pkg;
   typedef logic [15:0] pia_word_t;
   typedef enum logic [2:0] {
      S_PRE, S_IDLE, S_ST, S_OP, S_ADDR, S_TA, S_DATA, S_GAP
   } pia_mdio_st_t;
endpackage
`default_nettype wire

//--- logic/pia_reg_if.sv
// Purpose: register access between frame engine and register bank
// Assumes: single clock domain
// Notes: rdata is registered one cycle after addr
`default_nettype none
interface pia_reg_if;
   logic wr;
   logic [4:0] addr;
   pia_pkg::pia_word_t wdata;
   pia_pkg::pia_word_t rdata;
   modport eng (output wr, output addr, output wdata, input rdata);
   modport bank (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- logic/pia_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are quasi-static or slow against the core clock
// Notes: no reset, so reset must be held for at least three edges
`default_nettype none
module pia_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge i_clk) begin
      meta_q <= i_d;
      o_q <= meta_q;
   end
endmodule
`default_nettype wire

//--- logic/pia_regs.sv
// Purpose: identifier, local advertisement and partner ability registers
// Assumes: straps already synchronised and stable during reset
// Notes: read data is registered from the address
`include "pia_map.svh"
`default_nettype none
module pia_regs #(
   parameter logic [5:0] OUI_LOW = 6'h2a,
   parameter logic [5:0] MODEL_BASIC = 6'h05,
   parameter logic [5:0] MODEL_ENH = 6'h06,
   parameter logic [3:0] REVISION = 4'h2
) (
   input wire logic i_clk,
   input wire logic i_srst,
   pia_reg_if.bank rb,
   input wire logic i_basic_mode,
   input wire logic [3:0] i_strap_tech,
   input wire logic i_lp_valid,
   input wire pia_pkg::pia_word_t i_lp_page,
   output pia_pkg::pia_word_t o_id,
   output pia_pkg::pia_word_t o_adv,
   output pia_pkg::pia_word_t o_lp
);
   // a literal cannot be part-selected, so the reset word gets a name
   localparam pia_pkg::pia_word_t ADV_RST = `PIA_ADV_RST;
   pia_pkg::pia_word_t adv_rst, adv_wr, rd_mux;
   logic [2:0] upper_rst;
   logic mode_basic_q;
   // enhanced mode keeps the nominal ones for the three upper bits
   assign upper_rst = i_basic_mode ? i_strap_tech[3:1] :
                      ADV_RST[`PIA_ADV_TECH_MSB:`PIA_ADV_UPPER_LSB];
   assign adv_rst = {ADV_RST[15:`PIA_ADV_TECH_MSB+1], upper_rst, i_strap_tech[0],
                     ADV_RST[`PIA_ADV_TECH_LSB-1:0]};
   assign adv_wr = rb.wdata & `PIA_ADV_WR_MASK;
   assign o_id = {OUI_LOW, mode_basic_q ? MODEL_BASIC : MODEL_ENH, REVISION};
   assign rd_mux = (rb.addr == `PIA_REG_ID_LOW) ? o_id :
                   (rb.addr == `PIA_REG_ADV) ? o_adv :
                   (rb.addr == `PIA_REG_LP) ? o_lp : 16'h0000;
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_adv <= adv_rst;
         o_lp <= 16'h0000;
         mode_basic_q <= i_basic_mode;
         rb.rdata <= 16'h0000;
      end else begin
         if (rb.wr && rb.addr == `PIA_REG_ADV) begin
            o_adv <= adv_wr;
         end
         if (i_lp_valid) begin
            o_lp <= i_lp_page & `PIA_LP_MASK;
         end
         rb.rdata <= rd_mux;
      end
   end
endmodule
`default_nettype wire

//--- logic/pia_top.sv
// Purpose: management access to identifier and auto-negotiation words
// Assumes: management clock far slower than the core clock
// Notes: mdc and mdio are sampled by the core clock, edges found here
`include "pia_map.svh"
`default_nettype none
// Function
// - identifier top six bits give oui low
// - model number bits nine to four, mode dependent
// - revision number in lowest four bits
// - next page request bit, writable, reset zero
// - asymmetric pause bit, writable, reset zero
// - symmetric pause bit, writable, reset zero
// - four-pair bit reads zero always
// - speed duplex bits writable, loaded from straps in basic mode, only the lowest one in enhanced mode
// - forced mode ignores speed duplex bits
// - selector field writable, resets to one
// - partner next page bit, reset zero
// - partner acknowledge bit, reset zero
// - partner remote fault bit, reset zero
// - partner pause abilities, reset zero
// - partner speed duplex abilities, reset zero
// - partner selector field, reset zero
// - preamble after reset or a malformed frame, otherwise gap and idle edge
module pia_top #(
   parameter logic [5:0] OUI_LOW = 6'h2a, // arbitrary value
   parameter logic [5:0] MODEL_BASIC = 6'h05, // arbitrary value
   parameter logic [5:0] MODEL_ENH = 6'h06, // arbitrary value
   parameter logic [3:0] REVISION = 4'h2 // arbitrary value
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // management pins
   input wire logic i_mdc,
   input wire logic i_mdio,
   output logic o_mdio,
   output logic o_mdio_oe,
   // bootstrap pins
   input wire logic [4:0] i_strap_phy_addr,
   input wire logic i_strap_basic_mode,
   input wire logic [3:0] i_strap_tech,
   // auto-negotiation side
   input wire logic i_force_mode,
   input wire logic i_lp_valid,
   input wire pia_pkg::pia_word_t i_lp_page,
   output pia_pkg::pia_word_t o_an_adv,
   output pia_pkg::pia_word_t o_lp_ability
);
   pia_reg_if rif ();
   logic [1:0] pin_s;
   logic [9:0] strap_s;
   logic mdc_s, mdi, mdc_d_q, rise;
   logic [4:0] phy_addr_q;
   pia_pkg::pia_mdio_st_t st_q, st_d;
   logic [5:0] cnt_q, cnt_d;
   pia_pkg::pia_word_t sh_q, sh_d, wdata_q, wdata_d;
   logic rd_q, rd_d, hit_q, hit_d, wr_q, wr_d;
   logic mdo_q, mdo_d, oe_q, oe_d;
   logic [4:0] reg_q, reg_d;
   logic [1:0] op_w;
   logic [9:0] addr_w;
   pia_pkg::pia_word_t id_w, adv_w, an_adv_d;

   pia_sync #(.W(2)) u_pin_sync (
      .i_clk(i_core_clk),
      .i_d({i_mdc, i_mdio}),
      .o_q(pin_s)
   );
   pia_sync #(.W(10)) u_strap_sync (
      .i_clk(i_core_clk),
      .i_d({i_strap_phy_addr, i_strap_basic_mode, i_strap_tech}),
      .o_q(strap_s)
   );
   pia_regs #(
      .OUI_LOW(OUI_LOW),
      .MODEL_BASIC(MODEL_BASIC),
      .MODEL_ENH(MODEL_ENH),
      .REVISION(REVISION)
   ) u_regs (
      .i_clk(i_core_clk),
      .i_srst(i_srst),
      .rb(rif.bank),
      .i_basic_mode(strap_s[4]),
      .i_strap_tech(strap_s[3:0]),
      .i_lp_valid(i_lp_valid),
      .i_lp_page(i_lp_page),
      .o_id(id_w),
      .o_adv(adv_w),
      .o_lp(o_lp_ability)
   );

   assign mdc_s = pin_s[1];
   assign mdi = pin_s[0];
   assign rise = mdc_s & ~mdc_d_q;
   assign op_w = {sh_q[0], mdi};
   assign addr_w = {sh_q[8:0], mdi};
   assign rif.wr = wr_q;
   assign rif.addr = reg_q;
   assign rif.wdata = wdata_q;
   assign o_mdio = mdo_q;
   assign o_mdio_oe = oe_q;
   // forced links take speed and duplex elsewhere, so hide the bits
   assign an_adv_d = i_force_mode ?
      {adv_w[15:`PIA_ADV_TECH_MSB+1], 4'h0, adv_w[`PIA_ADV_TECH_LSB-1:0]} :
      adv_w;

   // frame engine: every step happens on a sampled rising mdc edge
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q + 6'h01;
      sh_d = {sh_q[14:0], mdi};
      rd_d = rd_q;
      hit_d = hit_q;
      reg_d = reg_q;
      mdo_d = mdo_q;
      oe_d = oe_q;
      wr_d = 1'b0;
      wdata_d = wdata_q;
      if (rise) begin
         unique case (st_q)
            pia_pkg::S_PRE: begin
               if (!mdi) begin
                  cnt_d = 6'h00;
               end else if (cnt_q == `PIA_PRE_LAST) begin
                  st_d = pia_pkg::S_IDLE;
               end
            end
            pia_pkg::S_IDLE: begin
               if (!mdi) begin
                  st_d = pia_pkg::S_ST;
               end
            end
            pia_pkg::S_ST: begin
               cnt_d = 6'h00;
               st_d = mdi ? pia_pkg::S_OP : pia_pkg::S_PRE;
            end
            pia_pkg::S_OP: begin
               if (cnt_q == 6'h01) begin
                  cnt_d = 6'h00;
                  rd_d = (op_w == `PIA_OP_RD);
                  // a bad opcode costs a full preamble again
                  st_d = (op_w == `PIA_OP_RD || op_w == `PIA_OP_WR) ?
                         pia_pkg::S_ADDR : pia_pkg::S_PRE;
               end
            end
            pia_pkg::S_ADDR: begin
               if (cnt_q == `PIA_ADDR_LAST) begin
                  cnt_d = 6'h00;
                  hit_d = (addr_w[9:5] == phy_addr_q);
                  reg_d = addr_w[4:0];
                  st_d = pia_pkg::S_TA;
               end
            end
            pia_pkg::S_TA: begin
               if (cnt_q == 6'h00) begin
                  if (rd_q && hit_q) begin
                     oe_d = 1'b1;
                     mdo_d = 1'b0;
                  end else if (!rd_q && !mdi) begin
                     cnt_d = 6'h00;
                     st_d = pia_pkg::S_PRE;
                  end
               end else begin
                  cnt_d = 6'h00;
                  if (rd_q) begin
                     // a foreign read leaves the data output at rest
                     if (hit_q) begin
                        mdo_d = rif.rdata[15];
                     end
                     sh_d = {rif.rdata[14:0], 1'b0};
                     st_d = pia_pkg::S_DATA;
                  end else if (mdi) begin
                     st_d = pia_pkg::S_PRE;
                  end else begin
                     st_d = pia_pkg::S_DATA;
                  end
               end
            end
            pia_pkg::S_DATA: begin
               if (rd_q) begin
                  if (hit_q) begin
                     mdo_d = sh_q[15];
                  end
                  sh_d = {sh_q[14:0], 1'b0};
               end
               if (cnt_q == `PIA_DATA_LAST) begin
                  oe_d = 1'b0;
                  mdo_d = 1'b0;
                  wr_d = !rd_q && hit_q;
                  wdata_d = {sh_q[14:0], mdi};
                  st_d = pia_pkg::S_GAP;
               end
            end
            pia_pkg::S_GAP: begin
               // the next frame may start only after an idle-high edge
               if (mdi) begin
                  st_d = pia_pkg::S_IDLE;
               end
            end
         endcase
      end else begin
         cnt_d = cnt_q;
         sh_d = sh_q;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_q <= pia_pkg::S_PRE;
         cnt_q <= 6'h00;
         sh_q <= 16'h0000;
         rd_q <= 1'b0;
         hit_q <= 1'b0;
         reg_q <= 5'h00;
         mdo_q <= 1'b0;
         oe_q <= 1'b0;
         wr_q <= 1'b0;
         wdata_q <= 16'h0000;
         mdc_d_q <= 1'b1;
         phy_addr_q <= strap_s[9:5];
         o_an_adv <= `PIA_ADV_RST;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         rd_q <= rd_d;
         hit_q <= hit_d;
         reg_q <= reg_d;
         mdo_q <= mdo_d;
         oe_q <= oe_d;
         wr_q <= wr_d;
         wdata_q <= wdata_d;
         mdc_d_q <= mdc_s;
         o_an_adv <= an_adv_d;
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_srst);

   logic adv_wr_w;
   assign adv_wr_w = wr_q && reg_q == `PIA_REG_ADV;

   chk_id_oui_field: assert property (id_w[15:10] == OUI_LOW)
      else $error("identifier oui bits wrong");
   chk_id_model_mode: assert property (
      id_w[9:4] == ($past(strap_s[4], 1) ? MODEL_BASIC : MODEL_ENH) || $stable(id_w[9:4]))
      else $error("model number does not follow pin mode");
   chk_id_revision: assert property (id_w[3:0] == REVISION)
      else $error("revision field wrong");
   chk_adv_np_write: assert property (adv_wr_w |=> adv_w[`PIA_ADV_NP] ==
      $past(wdata_q[`PIA_ADV_NP]))
      else $error("next page bit not written");
   chk_adv_pause_write: assert property (adv_wr_w |=>
      adv_w[`PIA_ADV_ASYM:`PIA_ADV_PAUSE] == $past(wdata_q[`PIA_ADV_ASYM:`PIA_ADV_PAUSE]))
      else $error("pause bits not written");
   chk_adv_t4_zero: assert property (adv_w[`PIA_ADV_T4] == 1'b0 && !adv_w[14] && !adv_w[12])
      else $error("read-only advertisement bit set");
   chk_adv_strap_load: assert property ($fell(i_srst) |->
      adv_w[`PIA_ADV_TECH_LSB] == $past(strap_s[0]) && adv_w[4:0] == `PIA_SEL_8023)
      else $error("strap or selector not loaded at reset");
   chk_adv_hold: assert property (!adv_wr_w |=> $stable(adv_w))
      else $error("advertisement changed without a write");
   chk_force_ignore: assert property (i_force_mode |=>
      o_an_adv[`PIA_ADV_TECH_MSB:`PIA_ADV_TECH_LSB] == 4'h0)
      else $error("speed bits used in forced mode");
   chk_lp_load: assert property (i_lp_valid |=>
      o_lp_ability == ($past(i_lp_page) & `PIA_LP_MASK))
      else $error("partner word not loaded");
   chk_lp_hold: assert property (!i_lp_valid |=> $stable(o_lp_ability))
      else $error("partner word changed without a page");
   chk_pre_count: assert property (st_q == pia_pkg::S_PRE && st_d == pia_pkg::S_IDLE |->
      rise && mdi && cnt_q == `PIA_PRE_LAST)
      else $error("preamble left early");
   chk_read_release: assert property ($fell(oe_q) |->
      $past(st_q) == pia_pkg::S_DATA && st_q == pia_pkg::S_GAP)
      else $error("mdio released outside end of data");

   cov_read_frame: cover property ($fell(oe_q));
   cov_adv_write: cover property (adv_wr_w);
   cov_pre_done: cover property (st_q == pia_pkg::S_PRE ##1 st_q == pia_pkg::S_IDLE);
   cov_lp_load: cover property (i_lp_valid ##1 o_lp_ability != 16'h0000);
   cov_force_mask: cover property (i_force_mode ##1 o_an_adv != adv_w);

   // reset itself is checked with the disable gate closed on purpose
   chk_reset_quiet: assert property (@(posedge i_core_clk) disable iff (1'b0)
      $past(i_srst) |-> !oe_q && !mdo_q && !wr_q)
      else $error("management pins active during reset");
   chk_lp_reset_zero: assert property (@(posedge i_core_clk) disable iff (1'b0)
      $past(i_srst) |-> o_lp_ability == 16'h0000)
      else $error("partner word not cleared by reset");

   // the line is only ever driven for a read aimed at this address
   chk_drive_hit_only: assert property (oe_q |-> rd_q && hit_q)
      else $error("mdio driven for a foreign frame");
   chk_drive_window: assert property (oe_q |->
      st_q == pia_pkg::S_TA || st_q == pia_pkg::S_DATA)
      else $error("mdio driven outside turnaround and data");
   // a resting data output keeps a later enable from glitching a one
   chk_quiet_when_off: assert property (!oe_q |-> !mdo_q)
      else $error("data out moves while released");
   chk_ta_start_low: assert property ($rose(oe_q) |-> !mdo_q && st_q == pia_pkg::S_TA)
      else $error("turnaround not driven low");
   chk_write_hit_only: assert property (wr_q |-> hit_q && !rd_q)
      else $error("write strobe without matching write frame");
   // the address strap is taken during reset only
   chk_addr_steady: assert property ($stable(phy_addr_q))
      else $error("station address changed outside reset");

   // unforced, the negotiation logic sees the register one cycle late
   chk_an_adv_follow: assert property (!i_force_mode |=> o_an_adv == $past(adv_w))
      else $error("advertisement not passed on");
endmodule
`default_nettype wire

//--- testbench/pia_smc_model.sv
// Purpose: station management controller driving mdc and mdio frames
// Assumes: device samples mdio on rising mdc; wire has a pull-up
// Notes: mdc stands low between frames; preamble sent only when need_pre is set
`default_nettype none
module pia_smc_model (
   output logic o_mdc,
   output logic o_mdio,
   output logic o_mdio_oe,
   input wire logic i_mdio_wire
);
   timeunit 1ns;
   timeprecision 100ps;
   logic need_pre = 1'b1;
   initial begin
      o_mdc = 1'b0;
      o_mdio = 1'b1;
      o_mdio_oe = 1'b0;
   end
   // data changes while mdc is low and holds across the rising edge
   task automatic clk_bit(input logic b);
      o_mdio = b;
      o_mdio_oe = 1'b1;
      #62.5 o_mdc = 1'b1;
      #62.5 o_mdc = 1'b0;
   endtask
   task automatic sample_bit(output logic b);
      o_mdio_oe = 1'b0;
      #62.5 b = i_mdio_wire;
      o_mdc = 1'b1;
      #62.5 o_mdc = 1'b0;
   endtask
   task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
         input logic [15:0] wd, output logic [15:0] rdat);
      logic [13:0] hdr;
      logic b;
      hdr = {2'b01, (rd ? 2'b10 : 2'b01), pa, ra};
      rdat = 16'h0000;
      if (need_pre) repeat (32) clk_bit(1'b1);
      need_pre = 1'b0;
      for (int i = 13; i >= 0; i--) clk_bit(hdr[i]);
      if (rd) begin
         for (int i = 0; i < 18; i++) begin
            sample_bit(b);
            if (i > 1) rdat = {rdat[14:0], b};
         end
      end else begin
         clk_bit(1'b1);
         clk_bit(1'b0);
         for (int i = 15; i >= 0; i--) clk_bit(wd[i]);
      end
      o_mdio_oe = 1'b0;
      #500;
      clk_bit(1'b1);
      o_mdio_oe = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- testbench/pia_top_tb_top.sv
// Purpose: self-checking bench for the identifier and advertisement bank
// Assumes: straps settle before reset is released
// Notes: reset is held six cycles since the synchronisers carry no reset
`default_nettype none
`define TB_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module pia_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [4:0] PA = 5'h01;
   localparam logic [5:0] OUI = 6'h2a; // arbitrary value
   localparam logic [5:0] MOD_B = 6'h05; // arbitrary value
   localparam logic [5:0] MOD_E = 6'h06; // arbitrary value
   localparam logic [3:0] REV = 4'h2; // arbitrary value
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic mdc, host_d, host_oe, dev_d, dev_oe;
   wire logic mdio_wire;
   logic basic = 1'b0;
   logic [3:0] tech = 4'ha;
   logic force_md = 1'b0;
   logic lp_valid = 1'b0;
   pia_pkg::pia_word_t lp_page = 16'h0000;
   pia_pkg::pia_word_t an_adv, lp_ab, adv_e;
   int err_total = 0;
   int checks_done = 0;
   always #5 clk = ~clk;
   assign mdio_wire = dev_oe ? dev_d : (host_oe ? host_d : 1'b1);
   pia_smc_model model (.o_mdc(mdc), .o_mdio(host_d), .o_mdio_oe(host_oe),
      .i_mdio_wire(mdio_wire));
   pia_top #(.OUI_LOW(OUI), .MODEL_BASIC(MOD_B), .MODEL_ENH(MOD_E), .REVISION(REV)) uut (
      .i_core_clk(clk), .i_srst(srst), .i_mdc(mdc), .i_mdio(mdio_wire), .o_mdio(dev_d),
      .o_mdio_oe(dev_oe), .i_strap_phy_addr(PA), .i_strap_basic_mode(basic),
      .i_strap_tech(tech), .i_force_mode(force_md), .i_lp_valid(lp_valid),
      .i_lp_page(lp_page), .o_an_adv(an_adv), .o_lp_ability(lp_ab));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic rd_chk(input logic [4:0] pa, input logic [4:0] ra, input pia_pkg::pia_word_t ex);
      pia_pkg::pia_word_t v;
      model.frame(1'b1, pa, ra, 16'h0000, v);
      `TB_CHK(v, ex)
   endtask
   task automatic wr(input logic [4:0] ra, input pia_pkg::pia_word_t wd);
      pia_pkg::pia_word_t v;
      model.frame(1'b0, PA, ra, wd, v);
   endtask
   task automatic t_reset(input logic bm, input logic [3:0] st);
      @(negedge clk);
      basic = bm;
      tech = st;
      srst = 1'b1;
      repeat (6) @(negedge clk);
      srst = 1'b0;
      model.need_pre = 1'b1;
      adv_e = {7'h00, (bm ? st[3:1] : 3'b111), st[0], 5'h01};
      repeat (4) @(negedge clk);
      rd_chk(PA, 5'h03, {OUI, (bm ? MOD_B : MOD_E), REV});
      rd_chk(PA, 5'h04, adv_e);
      rd_chk(PA, 5'h05, 16'h0000);
      `TB_CHK(an_adv, adv_e)
      `TB_CHK(lp_ab, 16'h0000)
      $display("reset values done, basic mode %0d", bm);
   endtask
   task automatic t_adv;
      pia_pkg::pia_word_t wv[3] = '{16'hcfff, 16'h0000, 16'h8c1e};
      for (int i = 0; i < 3; i++) begin
         wr(5'h04, wv[i]);
         rd_chk(PA, 5'h04, wv[i] & 16'hadff);
         @(negedge clk);
         `TB_CHK(an_adv, wv[i] & 16'hadff)
      end
      wr(5'h03, 16'h0000);
      rd_chk(PA, 5'h03, {OUI, MOD_E, REV});
      $display("advertisement writes done");
   endtask
   task automatic t_lp(input pia_pkg::pia_word_t pg);
      @(negedge clk);
      lp_valid = 1'b1;
      lp_page = pg;
      @(negedge clk);
      lp_valid = 1'b0;
      lp_page = ~pg;
      `TB_CHK(lp_ab, pg & 16'hefff)
      wr(5'h05, 16'h0000);
      rd_chk(PA, 5'h05, pg & 16'hefff);
      $display("partner page %h done", pg);
   endtask
   task automatic t_force;
      wr(5'h04, 16'h0de1);
      @(negedge clk);
      force_md = 1'b1;
      repeat (2) @(negedge clk);
      `TB_CHK(an_adv, 16'h0c01)
      rd_chk(PA, 5'h04, 16'h0de1);
      @(negedge clk);
      force_md = 1'b0;
      repeat (2) @(negedge clk);
      `TB_CHK(an_adv, 16'h0de1)
      $display("forced mode done");
   endtask
   task automatic t_refuse;
      // a foreign address leaves the line to the pull-up
      rd_chk(5'h1e, 5'h04, 16'hffff);
      rd_chk(PA, 5'h10, 16'h0000);
      $display("refused accesses done");
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      print_verdict();
   end
   initial begin
      t_reset(1'b0, 4'ha);
      t_adv();
      t_lp(16'hffff);
      t_lp(16'h4a21);
      t_force();
      t_refuse();
      t_reset(1'b1, 4'h5);
      print_verdict();
   end
endmodule
`default_nettype wire
